// ---- hw/msd_slice.sv ----
// operand, output and cascade selection of one multiply-add slice
`timescale 1ns/1ns
module msd_slice #(
   parameter int FIFO_DEPTH = msd_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr_bus,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [17:0] a,
   input wire logic [26:0] b,
   input wire logic [26:0] pre_a,
   input wire logic [26:0] pre_b,
   input wire logic [26:0] regf_data,
   input wire logic [2:0] reg_addr,
   input wire logic mshift,
   input wire logic cin,
   input wire logic fwdi_cin,
   input wire logic [26:0] fwdi_casc,
   input wire logic [26:0] revi_casc,
   input wire logic [63:0] fwdi_dout,
   input wire logic [31:0] revi_dout,
   output logic [26:0] fwdo_casc,
   output logic [26:0] revo_casc,
   output logic [63:0] fwdo_dout,
   output logic out_valid,
   input wire logic out_ready,
   output msd_pkg::msd_out_t out_word
);
   msd_pkg::msd_cfg_t cfg_reg;
   logic [63:0] dout_reg;
   logic [26:0] fwd_dly_reg;
   logic [26:0] rev_dly_reg;
   logic [3:0] flags_reg;
   logic [26:0] pre_res;
   logic [18:0] mul_a;
   logic [26:0] mul_b;
   logic [45:0] product;
   logic [63:0] op_a;
   logic [63:0] b_pick;
   logic [63:0] op_b;
   logic cin_v;
   logic [64:0] sum65;
   logic [48:0] sum_lo;
   logic [63:0] res;
   logic [47:0] wide;
   msd_pkg::msd_out_t out_next;
   logic fifo_ready;
   logic accept;
   logic [$clog2(FIFO_DEPTH):0] fifo_level;

   // back-pressure: the slice stalls while the fifo is full
   assign in_ready = fifo_ready;
   assign accept = in_valid && fifo_ready;

   // register port; config is static, written while the stream is idle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_reg <= msd_pkg::msd_cfg_t'(msd_pkg::CFG_RST);
      end else if (reg_wr && reg_addr_bus == msd_pkg::ADDR_CFG) begin
         cfg_reg <= msd_pkg::msd_cfg_t'(reg_wdata[msd_pkg::CFG_W-1:0]);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd && reg_addr_bus == msd_pkg::ADDR_CFG) begin
         reg_rdata <= {15'h0, cfg_reg};
      end else if (reg_rd && reg_addr_bus == msd_pkg::ADDR_STAT) begin
         reg_rdata <= {{(28 - $bits(fifo_level)){1'b0}}, fifo_level, flags_reg};
      end else begin
         reg_rdata <= 32'h0;
      end
   end

   // pre-adder
   always_comb begin
      case (cfg_reg.pre_mode)
         msd_pkg::SEL0: pre_res = pre_a + pre_b;
         msd_pkg::SEL1: pre_res = pre_a - pre_b;
         msd_pkg::SEL2: pre_res = pre_b - pre_a;
         default: pre_res = 27'h0;
      endcase
   end

   always_comb begin
      case (cfg_reg.mult_a_sel)
         msd_pkg::SEL0: mul_a = {a[17], a};
         msd_pkg::SEL1: mul_a = pre_res[18:0];
         msd_pkg::SEL2: mul_a = regf_data[18:0];
         default: mul_a = {1'b0, a};
      endcase
   end

   always_comb begin
      case (cfg_reg.mult_b_sel)
         msd_pkg::SEL0: mul_b = b;
         msd_pkg::SEL1: mul_b = fwdi_casc;
         msd_pkg::SEL2: mul_b = pre_res;
         default: mul_b = regf_data;
      endcase
   end

   // zero-extended a keeps bit 18 clear, so a signed product is still right
   assign product = 46'($signed(mul_a) * $signed(mul_b));

   always_comb begin
      case (cfg_reg.addsub_a_sel)
         msd_pkg::SEL0: op_a = {{18{product[45]}}, product};
         msd_pkg::SEL1: op_a = {{18{product[45]}}, product} << msd_pkg::MUL_SHIFT;
         msd_pkg::SEL2: op_a = {{16{reg_addr[2]}}, reg_addr, a, b};
         default: op_a = fwdi_dout;
      endcase
   end

   assign b_pick = cfg_reg.addsub_b_sel ? fwdi_dout : dout_reg;
   // arithmetic shift keeps the sign of an accumulated partial sum
   assign op_b = mshift ? 64'($signed(b_pick) >>> msd_pkg::MSH_SHIFT) : b_pick;
   assign cin_v = cfg_reg.cin_sel ? fwdi_cin : cin;

   assign sum65 = {1'b0, op_a} + {1'b0, op_b} + {64'h0, cin_v};
   assign sum_lo = {1'b0, op_a[47:0]} + {1'b0, op_b[47:0]} + {48'h0, cin_v};
   assign res = cfg_reg.bypass ? op_a : sum65[63:0];

   always_comb begin
      case (cfg_reg.out_sel)
         msd_pkg::SEL0: wide = res[47:0];
         msd_pkg::SEL1: wide = {16'h0, res[63:32]};
         msd_pkg::SEL2: wide = {16'h0, revi_dout};
         default: wide = 48'h0;
      endcase
   end

   always_comb begin
      out_next.dout = wide[44:0];
      if (cfg_reg.mode48) begin
         out_next.over_pos = wide[47];
         out_next.over_neg = wide[46];
         out_next.match = wide[45];
         out_next.cout = sum_lo[48];
      end else begin
         // overflow needs both operands of one sign and a result of the other
         out_next.over_pos = ~cfg_reg.bypass & ~op_a[63] & ~op_b[63] & sum65[63];
         out_next.over_neg = ~cfg_reg.bypass & op_a[63] & op_b[63] & ~sum65[63];
         out_next.match = (res == 64'h0);
         out_next.cout = sum65[64];
      end
   end

   always_comb begin
      case (cfg_reg.fwdo_sel)
         msd_pkg::SEL0: fwdo_dout = res;
         msd_pkg::SEL1: fwdo_dout = dout_reg;
         msd_pkg::SEL2: fwdo_dout = fwdi_dout;
         default: fwdo_dout = 64'h0;
      endcase
   end

   // output register and data cascade delays advance on accepted operands
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dout_reg <= 64'h0;
         flags_reg <= 4'h0;
      end else if (accept) begin
         dout_reg <= res;
         flags_reg <= {out_next.over_pos, out_next.over_neg, out_next.match, out_next.cout};
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fwd_dly_reg <= 27'h0;
         rev_dly_reg <= 27'h0;
      end else if (accept) begin
         fwd_dly_reg <= b;
         rev_dly_reg <= cfg_reg.rev_sel ? fwd_dly_reg : revi_casc;
      end
   end

   assign fwdo_casc = fwd_dly_reg;
   assign revo_casc = rev_dly_reg;

   msd_fifo #(
      .WIDTH(msd_pkg::OUT_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(in_valid),
      .in_ready(fifo_ready),
      .in_data(out_next),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_word),
      .level(fifo_level)
   );

   // checks
   pre_sub_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.pre_mode == msd_pkg::SEL2 |-> pre_res == 27'(pre_b - pre_a))
      else $error("pre-adder b minus a wrong");
   mula_zext_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.mult_a_sel == msd_pkg::SEL3 |-> !mul_a[18] && mul_a[17:0] == a)
      else $error("unsigned a not zero-extended");
   mulb_casc_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.mult_b_sel == msd_pkg::SEL1 |-> mul_b == fwdi_casc)
      else $error("multiplier b not from cascade");
   bypass_reg_a: assert property (@(posedge clk) disable iff (sys_rst)
      accept && cfg_reg.bypass |=> dout_reg == $past(op_a))
      else $error("bypass did not pass a operand");
   shift_b_a: assert property (@(posedge clk) disable iff (sys_rst)
      mshift && !b_pick[63] |-> op_b[63:47] == 17'h0 && op_b[46:0] == b_pick[63:17])
      else $error("mshift right shift wrong");
   cin_pick_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.cin_sel |-> cin_v == fwdi_cin)
      else $error("carry-in not from below");
   upper_out_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.out_sel == msd_pkg::SEL1 |-> out_next.dout == {13'h0, res[63:32]})
      else $error("upper word mapping wrong");
   wide_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.mode48 && cfg_reg.out_sel == msd_pkg::SEL0
      |-> {out_next.over_pos, out_next.over_neg, out_next.match} == res[47:45])
      else $error("48-bit flag mapping wrong");
   carry48_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.mode48 |-> out_next.cout == sum_lo[48])
      else $error("48-bit carry wrong");
   casc_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.fwdo_sel == msd_pkg::SEL3 |-> fwdo_dout == 64'h0)
      else $error("undefined cascade select not zero");
   rev_loop_a: assert property (@(posedge clk) disable iff (sys_rst)
      accept ##1 accept && cfg_reg.rev_sel |=> revo_casc == $past(b, 2))
      else $error("reverse loopback wrong");
   pre_add_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.pre_mode == msd_pkg::SEL0 |-> pre_res == 27'(pre_a + pre_b))
      else $error("pre-adder sum wrong");
   pre_diff_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.pre_mode == msd_pkg::SEL1 |-> pre_res == 27'(pre_a - pre_b))
      else $error("pre-adder a minus b wrong");
   mula_sext_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.mult_a_sel == msd_pkg::SEL0 |-> mul_a == {a[17], a})
      else $error("signed a not sign-extended");
   mulb_regf_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.mult_b_sel == msd_pkg::SEL3 |-> mul_b == regf_data)
      else $error("multiplier b not from register file");
   cat_sext_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.addsub_a_sel == msd_pkg::SEL2 |-> op_a[63:48] == {16{reg_addr[2]}} && op_a[47:0] == {reg_addr, a, b})
      else $error("concatenated a operand wrong");
   acc_pick_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.addsub_b_sel && !mshift |-> op_b == fwdi_dout)
      else $error("add/sub b not from below");
   no_shift_a: assert property (@(posedge clk) disable iff (sys_rst)
      !mshift |-> op_b == b_pick)
      else $error("b shifted without mshift");
   own_cin_a: assert property (@(posedge clk) disable iff (sys_rst)
      !cfg_reg.cin_sel |-> cin_v == cin)
      else $error("carry-in not from own pin");
   above_out_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.out_sel == msd_pkg::SEL2 |-> out_next.dout == {13'h0, revi_dout})
      else $error("upper slice mapping wrong");
   out_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.out_sel == msd_pkg::SEL3 |-> out_next.dout == 45'h0)
      else $error("undefined output select not zero");
   carry64_a: assert property (@(posedge clk) disable iff (sys_rst)
      !cfg_reg.mode48 |-> out_next.cout == sum65[64])
      else $error("64-bit carry wrong");
   casc_reg_a: assert property (@(posedge clk) disable iff (sys_rst)
      accept ##1 cfg_reg.fwdo_sel == msd_pkg::SEL1 |-> fwdo_dout == $past(res))
      else $error("registered cascade out wrong");
   casc_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_reg.fwdo_sel == msd_pkg::SEL2 |-> fwdo_dout == fwdi_dout)
      else $error("cascade pass-through wrong");
   full_stall_a: assert property (@(posedge clk) disable iff (sys_rst)
      !in_ready && !out_ready |=> !in_ready)
      else $error("fifo not holding full");

   fir_mid_c: cover property (@(posedge clk) disable iff (sys_rst) accept && cfg_reg.rev_sel);
   acc_loop_c: cover property (@(posedge clk) disable iff (sys_rst)
      accept && !cfg_reg.addsub_b_sel ##1 accept);
   wide_mode_c: cover property (@(posedge clk) disable iff (sys_rst) accept && cfg_reg.mode48);
   fifo_full_c: cover property (@(posedge clk) disable iff (sys_rst) in_valid && !in_ready);
   acc_casc_c: cover property (@(posedge clk) disable iff (sys_rst) accept && cfg_reg.addsub_b_sel);
endmodule

// ---- hw/msd_pkg.sv ----
// shared constants and carrier types for the multiply-add slice selects
package msd_pkg;
   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam int CFG_W = 17;
   localparam logic [CFG_W-1:0] CFG_RST = 17'h00000;
   localparam int MUL_SHIFT = 18;
   localparam int MSH_SHIFT = 17;
   localparam int FIFO_DEPTH = 16;
   localparam int OUT_W = 49;
   // two-bit select codes
   localparam logic [1:0] SEL0 = 2'h0;
   localparam logic [1:0] SEL1 = 2'h1;
   localparam logic [1:0] SEL2 = 2'h2;
   localparam logic [1:0] SEL3 = 2'h3;

   // field order from msb down to bit 0 of the config word
   typedef struct packed {
      logic [1:0] fwdo_sel;
      logic mode48;
      logic [1:0] out_sel;
      logic cin_sel;
      logic addsub_b_sel;
      logic [1:0] addsub_a_sel;
      logic bypass;
      logic [1:0] mult_b_sel;
      logic [1:0] mult_a_sel;
      logic [1:0] pre_mode;
      logic rev_sel;
   } msd_cfg_t;

   typedef struct packed {
      logic over_pos;
      logic over_neg;
      logic match;
      logic cout;
      logic [44:0] dout;
   } msd_out_t;
endpackage

// ---- hw/msd_fifo.sv ----
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module msd_fifo #(
   parameter int WIDTH = 49,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW:0] count_reg;
   logic push;
   logic pop;

   assign in_ready = (count_reg != (PW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr_reg];
   assign level = count_reg;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      end
   end
endmodule

// ---- testbench/msd_nbr.sv ----
// neighbour slices above and below that feed the cascade inputs
`timescale 1ns/1ns
module msd_nbr (
   input wire logic clk,
   output logic fwdi_cin,
   output logic [26:0] fwdi_casc,
   output logic [26:0] revi_casc,
   output logic [63:0] fwdi_dout,
   output logic [31:0] revi_dout
);
   // neighbours are registered, so values move only just after an edge
   task put(input logic ci, input logic [26:0] fc, rc, input logic [63:0] fd,
      input logic [31:0] rd);
      @(posedge clk);
      fwdi_cin <= ci;
      fwdi_casc <= fc;
      revi_casc <= rc;
      fwdi_dout <= fd;
      revi_dout <= rd;
   endtask
   initial begin
      fwdi_cin = 1'b0;
      fwdi_casc = 27'h0;
      revi_casc = 27'h0;
      fwdi_dout = 64'h0;
      revi_dout = 32'h0;
   end
endmodule

// ---- testbench/msd_slice_tb.sv ----
// self-checking bench for the multiply-add slice selects
`timescale 1ns/1ns
module msd_slice_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr_bus = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0, in_valid = 1'b0, out_ready = 1'b0;
   logic mshift = 1'b0, cin = 1'b0, in_ready, out_valid, fwdi_cin;
   logic [17:0] a = 18'h0;
   logic [26:0] b = 27'h0, pre_a = 27'h0, pre_b = 27'h0, regf_data = 27'h0;
   logic [2:0] reg_addr = 3'h0;
   logic [26:0] fwdi_casc, revi_casc, fwdo_casc, revo_casc;
   logic [63:0] fwdi_dout, fwdo_dout;
   logic [31:0] revi_dout;
   msd_pkg::msd_out_t out_word, o;
   msd_pkg::msd_cfg_t c;
   int fail_count = 0;
   int n_checks = 0;

   always #5 clk = ~clk;

   msd_slice dut (.clk, .sys_rst, .reg_addr_bus, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .in_valid, .in_ready, .a, .b, .pre_a, .pre_b, .regf_data, .reg_addr, .mshift, .cin,
      .fwdi_cin, .fwdi_casc, .revi_casc, .fwdi_dout, .revi_dout, .fwdo_casc, .revo_casc,
      .fwdo_dout, .out_valid, .out_ready, .out_word);
   msd_nbr nbr (.clk, .fwdi_cin, .fwdi_casc, .revi_casc, .fwdi_dout, .revi_dout);

   task chk(input logic [63:0] s, input logic [63:0] e);
      n_checks++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task end_sim;
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   function automatic logic [47:0] w48(msd_pkg::msd_out_t x);
      return {x.over_pos, x.over_neg, x.match, x.dout};
   endfunction
   task wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr_bus <= ad;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] ad, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr_bus <= ad;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(64'(reg_rdata), 64'(e));
   endtask
   task setc;
      wr(msd_pkg::ADDR_CFG, 32'(c));
   endtask
   // one operand set in, one word out; fifo assumed empty on entry
   task run(output msd_pkg::msd_out_t ow);
      @(posedge clk);
      in_valid <= 1'b1;
      @(posedge clk);
      in_valid <= 1'b0;
      out_ready <= 1'b1;
      #1;
      chk(64'(out_valid), 64'h1);
      ow = out_word;
      @(posedge clk);
      out_ready <= 1'b0;
   endtask
   task mul(input logic [1:0] ma, mb, pm, sa, input logic [47:0] e);
      c.mult_a_sel = ma;
      c.mult_b_sel = mb;
      c.pre_mode = pm;
      c.addsub_a_sel = sa;
      setc();
      run(o);
      chk(64'(w48(o)), 64'(e));
   endtask

   task t_regs;
      rd(msd_pkg::ADDR_CFG, 32'h0);
      wr(msd_pkg::ADDR_CFG, 32'hFFFFFFFF);
      rd(msd_pkg::ADDR_CFG, 32'h0001FFFF);
      wr(8'h08, 32'h5);
      rd(8'h08, 32'h0);
      wr(msd_pkg::ADDR_STAT, 32'hFF);
      rd(msd_pkg::ADDR_STAT, 32'h0);
   endtask
   task t_mult;
      c = '0;
      c.bypass = 1'b1;
      c.mode48 = 1'b1;
      nbr.put(1'b0, 27'hB, 27'h0, 64'h0, 32'h0);
      a <= 18'h3FFFF;
      b <= 27'h3;
      pre_a <= 27'h5;
      pre_b <= 27'h3;
      regf_data <= 27'h7;
      mul(2'h0, 2'h0, 2'h0, 2'h0, 48'hFFFFFFFFFFFD);
      mul(2'h3, 2'h0, 2'h0, 2'h0, 48'hBFFFD);
      mul(2'h1, 2'h0, 2'h0, 2'h0, 48'h18);
      mul(2'h1, 2'h0, 2'h1, 2'h0, 48'h6);
      mul(2'h1, 2'h0, 2'h2, 2'h0, 48'hFFFFFFFFFFFA);
      mul(2'h1, 2'h0, 2'h3, 2'h0, 48'h0);
      mul(2'h2, 2'h1, 2'h0, 2'h0, 48'h4D);
      mul(2'h2, 2'h2, 2'h0, 2'h0, 48'h38);
      mul(2'h2, 2'h3, 2'h0, 2'h0, 48'h31);
      mul(2'h1, 2'h0, 2'h0, 2'h1, 48'h600000);
   endtask
   task t_cat;
      logic [63:0] r;
      logic [63:0] ef [4];
      logic [44:0] ed [4];
      r = {16'hFFFF, 3'h5, 18'h2ABCD, 27'h5123456};
      ef = '{r, r, 64'h0123456789ABCDEF, 64'h0};
      ed = '{r[44:0], {13'h0, r[63:32]}, {13'h0, 32'hCAFE1234}, 45'h0};
      nbr.put(1'b0, 27'h0, 27'h0, 64'h0123456789ABCDEF, 32'hCAFE1234);
      reg_addr <= 3'h5;
      a <= 18'h2ABCD;
      b <= 27'h5123456;
      c = '0;
      c.bypass = 1'b1;
      c.mode48 = 1'b1;
      c.addsub_a_sel = msd_pkg::SEL2;
      for (int i = 0; i < 4; i++) begin
         c.out_sel = 2'(i);
         c.fwdo_sel = 2'(i);
         setc();
         @(posedge clk);
         #1;
         chk(fwdo_dout, ef[i]);
         run(o);
         chk(64'(o.dout), 64'(ed[i]));
         if (i == 0) begin
            chk(64'(w48(o)), 64'(r[47:0]));
         end
      end
   endtask
   task t_add;
      logic [63:0] x, y, s;
      logic [48:0] s48;
      x = 64'h0000C00000000001;
      nbr.put(1'b0, 27'h0, 27'h0, x, 32'h0);
      cin <= 1'b1;
      c = '0;
      c.addsub_a_sel = msd_pkg::SEL3;
      c.addsub_b_sel = 1'b1;
      c.mode48 = 1'b1;
      for (int i = 0; i < 4; i++) begin
         c.cin_sel = i[0];
         mshift <= i[1];
         setc();
         y = i[1] ? 64'($signed(x) >>> 17) : x;
         s = x + y + 64'(!i[0]);
         s48 = {1'b0, x[47:0]} + {1'b0, y[47:0]} + 49'(!i[0]);
         run(o);
         chk(64'(w48(o)), 64'(s[47:0]));
         chk(64'(o.cout), 64'(s48[48]));
      end
      nbr.put(1'b0, 27'h0, 27'h0, 64'h8000000000000000, 32'h0);
      mshift <= 1'b0;
      c.mode48 = 1'b0;
      setc();
      run(o);
      chk(64'({o.over_pos, o.over_neg, o.match, o.cout}), 64'h7);
      nbr.put(1'b0, 27'h0, 27'h0, 64'h5, 32'h0);
      c.addsub_b_sel = 1'b0;
      setc();
      run(o);
      run(o);
      chk(64'(o.dout), 64'hA);
   endtask
   task t_casc;
      nbr.put(1'b0, 27'h0, 27'h1234567, 64'h0, 32'h0);
      b <= 27'h0ABCDEF;
      c = '0;
      setc();
      run(o);
      chk(64'(revo_casc), 64'h1234567);
      b <= 27'h7654321;
      c.rev_sel = 1'b1;
      setc();
      run(o);
      chk(64'(revo_casc), 64'h0ABCDEF);
   endtask
   // consumer stalls while seventeen sets are offered; the last must be refused
   task t_fifo;
      c = '0;
      c.bypass = 1'b1;
      c.rev_sel = 1'b1;
      c.addsub_a_sel = msd_pkg::SEL2;
      setc();
      a <= 18'h0;
      reg_addr <= 3'h0;
      @(posedge clk);
      for (int i = 0; i < 17; i++) begin
         in_valid <= 1'b1;
         b <= 27'(i);
         @(posedge clk);
      end
      in_valid <= 1'b0;
      #1;
      chk(64'(in_ready), 64'h0);
      chk(64'(fwdo_casc), 64'hF);
      chk(64'(revo_casc), 64'hE);
      @(posedge clk);
      out_ready <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         #1;
         chk(64'(out_valid), 64'h1);
         chk(64'(out_word.dout), 64'(i));
         @(posedge clk);
      end
      out_ready <= 1'b0;
      #1;
      chk(64'(out_valid), 64'h0);
   endtask

   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      t_mult();
      t_cat();
      t_add();
      t_casc();
      t_fifo();
      end_sim();
   end
   initial begin
      #200000;
      fail_count++;
      end_sim();
   end
endmodule
